// *** verilog/status_flags_pkg.sv ***
package status_flags_pkg;
    localparam int NUM_AXES = 3;
    localparam int SPEED_W = 16;
    localparam int TORQUE_W = 16;
    // control modes of an axis
    typedef enum logic [1:0] {
        MODE_POSITION = 2'h0,
        MODE_SPEED = 2'h1,
        MODE_TORQUE = 2'h2
    } ctrl_mode_t;
    // speed units: r/min, or mm/s for a linear motor
    localparam logic [SPEED_W-1:0] ZERO_SPEED_DEFAULT = 16'h0032;
    localparam logic [SPEED_W-1:0] ZERO_SPEED_HYST = 16'h0014;
    // register map
    localparam logic [3:0] ADDR_ZERO_THRESH = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h2;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
    localparam logic [3:0] ADDR_FLAGS = 4'h4;
    localparam int FLAG_SPEED_LIM = 0;
    localparam int FLAG_TORQUE_LIM = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_WARN = 3;
    localparam int FLAGS_PER_AXIS = 4;
    // power-on hold of the warning output
    localparam int POWERON_MS = 3000;
    localparam int CLK_KHZ = 50000;
    localparam int POWERON_CYCLES = POWERON_MS * CLK_KHZ;
endpackage : status_flags_pkg

// *** verilog/zero_speed_detect.sv ***
module zero_speed_detect #(
    parameter int SPEED_W = status_flags_pkg::SPEED_W
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // speed and threshold
    input wire logic signed [SPEED_W-1:0] speed_i,
    input wire logic [SPEED_W-1:0] thresh_i,
    // result
    output logic zero_o
);
    logic zero_reg;
    logic zero_next;
    wire logic [SPEED_W-1:0] abs_speed;
    wire logic [SPEED_W:0] off_level;
    wire logic at_on;
    wire logic past_off;

    assign abs_speed = speed_i[SPEED_W-1] ? SPEED_W'(-speed_i) : speed_i; // R9
    assign off_level = {1'b0, thresh_i} + {1'b0, status_flags_pkg::ZERO_SPEED_HYST}; // R10
    assign at_on = abs_speed <= thresh_i; // R7
    // forward reaching +off or reverse reaching -off both release
    assign past_off = {1'b0, abs_speed} >= off_level; // R8 R9
    assign zero_next = at_on ? 1'b1 : (past_off ? 1'b0 : zero_reg);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zero_reg <= 1'b0;
        end else begin
            zero_reg <= zero_next;
        end
    end

    assign zero_o = zero_reg;
endmodule : zero_speed_detect

// *** verilog/servo_status_flags.sv ***
// What this block does
// R1 - in torque mode, speed-limit flag sets when speed reaches its limit
// R2 - speed-limit flag is cleared while the axis is servo-off
// R3 - speed-limit flag stays off in position and speed modes
// R4 - torque-limit flag sets when generated torque reaches the limit
// R5 - torque-limit flag forced off while the axis is servo-off
// R6 - torque-limit flag stays off in torque mode
// R7 - zero-speed flag sets when absolute speed at or below threshold
// R8 - zero-speed flag holds until forward speed reaches the off level
// R9 - reverse direction uses the mirrored on and off levels
// R10 - off level sits a fixed 20 above the on level
// R11 - for linear motors the same figures count in mm/s
// R12 - warning flag is on while a warning is active on the axis
// R13 - without a warning the flag goes off about 3 s after power-on
// R14 - all-axes output only when every present axis meets the condition
// R15 - any-axis output when any single present axis meets the condition
module servo_status_flags #(
    parameter int NUM_AXES = status_flags_pkg::NUM_AXES,
    parameter int SPEED_W = status_flags_pkg::SPEED_W,
    parameter int TORQUE_W = status_flags_pkg::TORQUE_W,
    parameter int POWERON_CYCLES = status_flags_pkg::POWERON_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // per-axis drive state
    input wire logic [NUM_AXES-1:0] axis_present_i,
    input wire logic [NUM_AXES-1:0] servo_on_i,
    input wire logic [2*NUM_AXES-1:0] ctrl_mode_i,
    input wire logic [NUM_AXES*SPEED_W-1:0] speed_i,
    input wire logic [NUM_AXES*SPEED_W-1:0] speed_limit_i,
    input wire logic [NUM_AXES*TORQUE_W-1:0] torque_i,
    input wire logic [NUM_AXES*TORQUE_W-1:0] torque_limit_i,
    input wire logic [NUM_AXES-1:0] warning_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // per-axis flags
    output logic [NUM_AXES-1:0] speed_limit_active_o,
    output logic [NUM_AXES-1:0] torque_limit_active_o,
    output logic [NUM_AXES-1:0] zero_speed_flag_o,
    output logic [NUM_AXES-1:0] warning_flag_o,
    // combined flags
    output logic speed_limit_all_axes_o,
    output logic speed_limit_any_axis_o,
    output logic torque_limit_all_axes_o,
    output logic torque_limit_any_axis_o,
    output logic zero_speed_all_axes_o,
    output logic zero_speed_any_axis_o,
    output logic warning_all_axes_o,
    output logic warning_any_axis_o,
    // interrupt
    output logic irq_o
);
    localparam int NFLAG = status_flags_pkg::FLAGS_PER_AXIS * NUM_AXES;
    localparam int CNT_W = $clog2(POWERON_CYCLES + 1);

    // absolute value of a signed quantity, used for speed and torque
    function automatic logic [SPEED_W-1:0] mag(input logic [SPEED_W-1:0] v);
        mag = v[SPEED_W-1] ? SPEED_W'(-v) : v;
    endfunction : mag

    logic [SPEED_W-1:0] zero_thresh_reg;
    logic [NFLAG-1:0] irq_status_reg;
    logic [NFLAG-1:0] irq_enable_reg;
    logic [NFLAG-1:0] flags_prev_reg;
    logic [CNT_W-1:0] poweron_cnt_reg;
    logic poweron_done_reg;
    logic [31:0] reg_rdata_reg;
    logic [NUM_AXES-1:0] speed_lim_reg;
    logic [NUM_AXES-1:0] torque_lim_reg;
    logic [NUM_AXES-1:0] warn_reg;
    logic [7:0] comb_reg;
    logic irq_reg;

    wire logic [NUM_AXES-1:0] speed_lim_next;
    wire logic [NUM_AXES-1:0] torque_lim_next;
    wire logic [NUM_AXES-1:0] zero_now;
    wire logic [NUM_AXES-1:0] warn_next;
    wire logic [NFLAG-1:0] flags_now;
    wire logic [NFLAG-1:0] flag_rise;
    wire logic [NFLAG-1:0] irq_status_next;
    wire logic [7:0] comb_next;
    wire logic wr_thresh;
    wire logic wr_clear;
    wire logic wr_enable;
    wire logic [NFLAG-1:0] irq_enable_next;
    wire logic [31:0] rd_mux;

    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_axis
            wire logic [1:0] mode;
            wire logic [SPEED_W-1:0] spd;
            wire logic [TORQUE_W-1:0] trq;
            assign mode = ctrl_mode_i[2*g +: 2];
            assign spd = speed_i[g*SPEED_W +: SPEED_W];
            assign trq = torque_i[g*TORQUE_W +: TORQUE_W];
            assign speed_lim_next[g] = servo_on_i[g] // R2
                && (mode == status_flags_pkg::MODE_TORQUE) // R3
                && (mag(spd) >= speed_limit_i[g*SPEED_W +: SPEED_W]); // R1
            assign torque_lim_next[g] = servo_on_i[g] // R5
                && (mode != status_flags_pkg::MODE_TORQUE) // R6
                && (mag(trq) >= torque_limit_i[g*TORQUE_W +: TORQUE_W]); // R4
            // before the power-on hold ends the warning output reads on
            assign warn_next[g] = warning_i[g] || !poweron_done_reg; // R12 R13

            zero_speed_detect #(
                .SPEED_W(SPEED_W)
            ) u_zero (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .speed_i(spd),
                .thresh_i(zero_thresh_reg), // R11
                .zero_o(zero_now[g])
            );

            assign flags_now[g*status_flags_pkg::FLAGS_PER_AXIS +: status_flags_pkg::FLAGS_PER_AXIS] =
                {warn_reg[g], zero_now[g], torque_lim_reg[g], speed_lim_reg[g]};
        end
    endgenerate

    // absent axes count as met for AND and as not met for OR
    assign comb_next[0] = &(speed_lim_reg | ~axis_present_i); // R14
    assign comb_next[1] = |(speed_lim_reg & axis_present_i); // R15
    assign comb_next[2] = &(torque_lim_reg | ~axis_present_i); // R14
    assign comb_next[3] = |(torque_lim_reg & axis_present_i); // R15
    assign comb_next[4] = &(zero_now | ~axis_present_i); // R14
    assign comb_next[5] = |(zero_now & axis_present_i); // R15
    assign comb_next[6] = &(warn_reg | ~axis_present_i); // R14
    assign comb_next[7] = |(warn_reg & axis_present_i); // R15

    assign wr_thresh = reg_wr_i && (reg_addr_i == status_flags_pkg::ADDR_ZERO_THRESH);
    assign wr_clear = reg_wr_i && (reg_addr_i == status_flags_pkg::ADDR_IRQ_CLEAR);
    assign wr_enable = reg_wr_i && (reg_addr_i == status_flags_pkg::ADDR_IRQ_ENABLE);
    // irq follows the enable register without a cycle of lag after a write
    assign irq_enable_next = wr_enable ? reg_wdata_i[NFLAG-1:0] : irq_enable_reg;

    // rising edge of any flag is an event; set beats a same-cycle clear
    assign flag_rise = flags_now & ~flags_prev_reg;
    assign irq_status_next = (irq_status_reg & ~(wr_clear ? reg_wdata_i[NFLAG-1:0] : '0))
        | flag_rise;

    assign rd_mux =
        (reg_addr_i == status_flags_pkg::ADDR_ZERO_THRESH) ? 32'(zero_thresh_reg) :
        (reg_addr_i == status_flags_pkg::ADDR_IRQ_STATUS) ? 32'(irq_status_reg) :
        (reg_addr_i == status_flags_pkg::ADDR_IRQ_ENABLE) ? 32'(irq_enable_reg) :
        (reg_addr_i == status_flags_pkg::ADDR_FLAGS) ? 32'(flags_now) : 32'h0000_0000;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            poweron_cnt_reg <= '0;
            poweron_done_reg <= 1'b0;
        end else if (!poweron_done_reg) begin
            poweron_cnt_reg <= poweron_cnt_reg + CNT_W'(1);
            poweron_done_reg <= (poweron_cnt_reg == CNT_W'(POWERON_CYCLES - 1)); // R13
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zero_thresh_reg <= status_flags_pkg::ZERO_SPEED_DEFAULT;
            irq_enable_reg <= '0;
            irq_status_reg <= '0;
            flags_prev_reg <= '0;
            reg_rdata_reg <= 32'h0000_0000;
        end else begin
            if (wr_thresh) begin
                zero_thresh_reg <= reg_wdata_i[SPEED_W-1:0]; // R7
            end
            irq_enable_reg <= irq_enable_next;
            irq_status_reg <= irq_status_next;
            flags_prev_reg <= flags_now;
            reg_rdata_reg <= reg_rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_lim_reg <= '0;
            torque_lim_reg <= '0;
            warn_reg <= '0;
            comb_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            speed_lim_reg <= speed_lim_next;
            torque_lim_reg <= torque_lim_next;
            warn_reg <= warn_next;
            comb_reg <= comb_next;
            irq_reg <= |(irq_status_next & irq_enable_next);
        end
    end

    assign speed_limit_active_o = speed_lim_reg;
    assign torque_limit_active_o = torque_lim_reg;
    assign zero_speed_flag_o = zero_now;
    assign warning_flag_o = warn_reg;
    assign speed_limit_all_axes_o = comb_reg[0];
    assign speed_limit_any_axis_o = comb_reg[1];
    assign torque_limit_all_axes_o = comb_reg[2];
    assign torque_limit_any_axis_o = comb_reg[3];
    assign zero_speed_all_axes_o = comb_reg[4];
    assign zero_speed_any_axis_o = comb_reg[5];
    assign warning_all_axes_o = comb_reg[6];
    assign warning_any_axis_o = comb_reg[7];
    assign reg_rdata_o = reg_rdata_reg;
    assign irq_o = irq_reg;
endmodule : servo_status_flags

// *** bench/servo_status_flags_props.sv ***
module servo_status_flags_props #(
    parameter int POWERON_CYCLES = 20
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // watched inputs
    input wire logic [2:0] axis_present_i,
    input wire logic [2:0] servo_on_i,
    input wire logic [5:0] ctrl_mode_i,
    input wire logic [47:0] speed_i,
    input wire logic [47:0] speed_limit_i,
    input wire logic [2:0] warning_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // watched outputs
    input wire logic [2:0] speed_limit_active_o,
    input wire logic [2:0] torque_limit_active_o,
    input wire logic [2:0] zero_speed_flag_o,
    input wire logic [2:0] warning_flag_o,
    input wire logic torque_limit_all_axes_o,
    input wire logic zero_speed_any_axis_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mag, thr, cnt;
    logic lim_hit, zon, zoff, tall, zany;
    assign mag = speed_i[15] ? 16'h0 - speed_i[15:0] : speed_i[15:0];
    assign lim_hit = servo_on_i[0] && ctrl_mode_i[1:0] == status_flags_pkg::MODE_TORQUE
        && mag >= speed_limit_i[15:0];
    assign zon = mag <= thr;
    // one extra bit so a high threshold cannot wrap the off level
    assign zoff = {1'b0, mag} >= ({1'b0, thr} + {1'b0, status_flags_pkg::ZERO_SPEED_HYST});
    assign tall = &(torque_limit_active_o | ~axis_present_i);
    assign zany = |(zero_speed_flag_o & axis_present_i);
    // threshold mirrored from the port, cycle count saturates
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thr <= status_flags_pkg::ZERO_SPEED_DEFAULT;
            cnt <= 16'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == status_flags_pkg::ADDR_ZERO_THRESH) begin
                thr <= reg_wdata_i[15:0];
            end
            if (cnt != 16'hffff) begin
                cnt <= cnt + 16'h1;
            end
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_in_band;
        zero_speed_flag_o[0] && !zon && !zoff;
    endsequence
    a_speed_lim_set: assert property ($past(rst_n_i) |-> speed_limit_active_o[0] == $past(lim_hit))
        else $error("speed limit flag wrong");
    a_zero_on_level: assert property ($past(rst_n_i) && $past(zon) |-> zero_speed_flag_o[0])
        else $error("zero flag not set");
    a_zero_off_level: assert property ($past(rst_n_i) && $past(zoff) |-> !zero_speed_flag_o[0])
        else $error("zero flag not cleared");
    a_zero_band_hold: assert property (s_in_band |=> zero_speed_flag_o[0])
        else $error("zero flag dropped in band");
    a_warn_follows: assert property ($past(rst_n_i) && $past(warning_i[0]) |-> warning_flag_o[0])
        else $error("warning flag missing");
    a_warn_poweron_hold: assert property (cnt > 16'h1 && cnt < POWERON_CYCLES |-> &warning_flag_o)
        else $error("warning flag off in power-on");
    a_warn_poweron_end: assert property (cnt > POWERON_CYCLES + 2 && !$past(warning_i[0])
        |-> !warning_flag_o[0])
        else $error("warning flag stuck on");
    a_torque_all_axes: assert property ($past(rst_n_i) |-> torque_limit_all_axes_o == $past(tall))
        else $error("all-axes torque flag wrong");
    a_zero_any_axis: assert property ($past(rst_n_i) |-> zero_speed_any_axis_o == $past(zany))
        else $error("any-axis zero flag wrong");
endmodule : servo_status_flags_props

bind servo_status_flags servo_status_flags_props #(.POWERON_CYCLES(POWERON_CYCLES)) i_props (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .axis_present_i(axis_present_i),
    .servo_on_i(servo_on_i), .ctrl_mode_i(ctrl_mode_i), .speed_i(speed_i),
    .speed_limit_i(speed_limit_i), .warning_i(warning_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .speed_limit_active_o(speed_limit_active_o),
    .torque_limit_active_o(torque_limit_active_o), .zero_speed_flag_o(zero_speed_flag_o),
    .warning_flag_o(warning_flag_o), .torque_limit_all_axes_o(torque_limit_all_axes_o),
    .zero_speed_any_axis_o(zero_speed_any_axis_o)
);

// *** bench/flag_reader.sv ***
module flag_reader (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // combined flags from the drive
    input wire logic [7:0] comb_i,
    // last sample taken
    output logic [7:0] seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // polls every cycle; its own input filtering is not modelled
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_o <= 8'h0;
        end else begin
            seen_o <= comb_i;
        end
    end
endmodule : flag_reader

// *** bench/servo_status_flags_test.sv ***
module servo_status_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] present = 3'h7, son = 3'h0, warn = 3'h0, sla, tla, zf, wf, zm = 3'h7;
    logic [5:0] mode = 6'h0;
    logic [47:0] spd = 48'h0, slim = 48'h0, trq = 48'h0, tlim = 48'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rv, fx;
    logic wr = 1'b0, rd = 1'b0, irq;
    logic [7:0] comb, seen;
    logic [2:0] es, et;
    logic [15:0] thr = 16'h0032, c;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    servo_status_flags #(.POWERON_CYCLES(20)) i_servo_status_flags (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .axis_present_i(present), .servo_on_i(son),
        .ctrl_mode_i(mode), .speed_i(spd), .speed_limit_i(slim), .torque_i(trq),
        .torque_limit_i(tlim), .warning_i(warn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .speed_limit_active_o(sla),
        .torque_limit_active_o(tla), .zero_speed_flag_o(zf), .warning_flag_o(wf),
        .speed_limit_all_axes_o(comb[7]), .speed_limit_any_axis_o(comb[6]),
        .torque_limit_all_axes_o(comb[5]), .torque_limit_any_axis_o(comb[4]),
        .zero_speed_all_axes_o(comb[3]), .zero_speed_any_axis_o(comb[2]),
        .warning_all_axes_o(comb[1]), .warning_any_axis_o(comb[0]), .irq_o(irq));
    flag_reader i_flag_reader (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .comb_i(comb), .seen_o(seen));
    always #10 clk_sys_i = ~clk_sys_i;
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata;
    endtask : reg_rd
    function automatic logic [15:0] mag(input logic [15:0] v);
        return v[15] ? 16'h0 - v : v;
    endfunction : mag
    // tq low: speed-limit flags, tq high: torque-limit flags
    function automatic logic [2:0] exp_lim(input logic tq);
        logic [2:0] e;
        for (int k = 0; k < 3; k++) begin
            e[k] = son[k] && ((mode[2*k+:2] == status_flags_pkg::MODE_TORQUE) != tq)
                && (tq ? mag(trq[16*k+:16]) >= tlim[16*k+:16] : mag(spd[16*k+:16]) >= slim[16*k+:16]);
        end
        return e;
    endfunction : exp_lim
    task automatic zstep();
        for (int k = 0; k < 3; k++) begin
            if (mag(spd[16*k+:16]) <= thr) zm[k] = 1'b1;
            else if (mag(spd[16*k+:16]) >= thr + status_flags_pkg::ZERO_SPEED_HYST) zm[k] = 1'b0;
        end
    endtask : zstep
    function automatic logic [1:0] pair(input logic [2:0] f);
        return {&(f | ~present), |(f & present)};
    endfunction : pair
    initial begin
        void'($urandom(90714));
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        reg_rd(status_flags_pkg::ADDR_ZERO_THRESH, rv);
        check(rv, 32'h0000_0032);
        check(32'(wf), 32'h7);
        reg_rd(4'hf, rv);
        check(rv, 32'h0);
        repeat (20) @(posedge clk_sys_i);
        #1;
        check(32'(wf), 32'h0);
        for (int i = 0; i < 300; i++) begin
            if (i == 150) begin
                reg_wr(status_flags_pkg::ADDR_ZERO_THRESH, 32'h0000_0064);
                thr = 16'h0064;
                zstep();
            end
            @(posedge clk_sys_i);
            present <= (i % 3 == 0) ? 3'h3 : 3'h7;
            son <= 3'($urandom);
            warn <= 3'($urandom);
            for (int k = 0; k < 3; k++) begin
                mode[2*k+:2] <= 2'($urandom_range(2));
                c = (i % 4 == 0) ? thr + 16'($urandom_range(1) * 19 + $urandom_range(1)) : 16'h0;
                spd[16*k+:16] <= (i % 4 == 0) ? ($urandom_range(1) ? 16'h0 - c : c)
                    : 16'($urandom_range(300)) - 16'h0096;
                slim[16*k+:16] <= 16'($urandom_range(150));
                trq[16*k+:16] <= 16'($urandom_range(400)) - 16'h00c8;
                tlim[16*k+:16] <= 16'($urandom_range(200));
            end
            repeat (2) @(posedge clk_sys_i);
            #1;
            zstep();
            check(32'(sla), 32'(exp_lim(1'b0)));
            check(32'(tla), 32'(exp_lim(1'b1)));
            check(32'(zf), 32'(zm));
            check(32'(wf), 32'(warn));
            check(32'(comb), 32'({pair(exp_lim(1'b0)), pair(exp_lim(1'b1)), pair(zm), pair(warn)}));
        end
        es = exp_lim(1'b0);
        et = exp_lim(1'b1);
        fx = 32'h0000_0000;
        for (int k = 0; k < 3; k++) fx[4*k+:4] = {warn[k], zm[k], et[k], es[k]};
        reg_rd(status_flags_pkg::ADDR_FLAGS, rv);
        check(rv, fx);
        check(32'(seen), 32'({pair(es), pair(et), pair(zm), pair(warn)}));
        @(posedge clk_sys_i);
        son <= 3'h0;
        warn <= 3'h0;
        spd <= {3{16'h03e8}};
        repeat (4) @(posedge clk_sys_i);
        reg_wr(status_flags_pkg::ADDR_IRQ_ENABLE, 32'h0);
        reg_wr(status_flags_pkg::ADDR_IRQ_CLEAR, 32'h0000_0fff);
        spd[15:0] <= 16'h0;
        repeat (4) @(posedge clk_sys_i);
        reg_rd(status_flags_pkg::ADDR_IRQ_STATUS, rv);
        check(rv, 32'h4);
        check(32'(irq), 32'h0);
        reg_wr(status_flags_pkg::ADDR_IRQ_ENABLE, 32'h4);
        @(negedge clk_sys_i);
        check(32'(irq), 32'h1);
        reg_wr(status_flags_pkg::ADDR_IRQ_CLEAR, 32'h4);
        @(negedge clk_sys_i);
        check(32'(irq), 32'h0);
        finish_test();
    end
endmodule : servo_status_flags_test
